// ### inc/frm_cfg.svh
// Register map, field positions, reset values and widths of the fault reset bank
`ifndef FRM_CFG_SVH
`define FRM_CFG_SVH
`define FRM_ADDR_W 16
`define FRM_DATA_W 32
`define FRM_OFS_STICKY 16'h2030
`define FRM_OFS_UV_EN 16'h2034
`define FRM_OFS_OV_EN 16'h2038
`define FRM_OFS_WARN_EN 16'h203C
`define FRM_OFS_OT_EN 16'h2040
`define FRM_OFS_MISC_EN 16'h2044
`define FRM_OFS_IRQ_STAT 16'h2100
`define FRM_OFS_IRQ_MASK 16'h2104
`define FRM_STICKY_W 7
`define FRM_UV_W 15
`define FRM_OV_W 14
`define FRM_WARN_W 14
`define FRM_OT_W 12
`define FRM_MISC_W 6
`define FRM_MISC_LO 23
`define FRM_MISC_HI 28
`define FRM_CAT_N 5
`define FRM_IRQ_W 12
`define FRM_IRQ_CAT_LO 7
`define FRM_IRQ_CAT_HI 11
`define FRM_GATE_W 61
`define FRM_GATE_UV_LO 0
`define FRM_GATE_OV_LO 15
`define FRM_GATE_WARN_LO 29
`define FRM_GATE_OT_LO 43
`define FRM_GATE_MISC_LO 55
`define FRM_BIT_THERMAL 6
`define FRM_BIT_LDO5_OV 5
`define FRM_BIT_LDO3_OV 4
`define FRM_BIT_LDO1_OV 3
`define FRM_BIT_LDO5_UV 2
`define FRM_BIT_LDO3_UV 1
`define FRM_BIT_LDO1_UV 0
`define FRM_BIT_IO_LOCKOUT 14
`define FRM_BIT_MON_HI 13
`define FRM_BIT_MON_LO 12
`define FRM_MISC_WD1_EDGE 5
`define FRM_MISC_WD0_EDGE 4
`define FRM_MISC_OSEL 3
`define FRM_MISC_MODE 2
`define FRM_MISC_SYNC 1
`define FRM_MISC_WD1_PULSE 0
`define FRM_UV_RST_VAL 15'h4C27
`define FRM_OV_RST_VAL 14'h0C27
`define FRM_WARN_RST_VAL 14'h0000
`define FRM_OT_RST_VAL 12'h000
`define FRM_MISC_RST_VAL 6'h00
`define FRM_STICKY_RST_VAL 7'h00
`define FRM_IRQ_RST_VAL 12'h000
`define FRM_CAT_RST_VAL 5'h00
`define FRM_WORD_ZERO 32'h0000_0000
`endif

// ### inc/frm_pkg.sv
// Shared types of the fault reset bank
`include "frm_cfg.svh"
package frm_pkg;
    typedef logic [`FRM_DATA_W-1:0] frm_word_t;
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_STICKY,
        SEL_UV_EN,
        SEL_OV_EN,
        SEL_WARN_EN,
        SEL_OT_EN,
        SEL_MISC_EN,
        SEL_IRQ_STAT,
        SEL_IRQ_MASK
    } frm_reg_sel_t;
endpackage : frm_pkg

// ### inc/frm_core_if.sv
// Signals between the bank top and its latch and gate children
`timescale 1ns/1ns
`include "frm_cfg.svh"
interface frm_core_if;
    logic [`FRM_STICKY_W-1:0] stickyEvt;
    logic [`FRM_STICKY_W-1:0] stickyClr;
    logic [`FRM_STICKY_W-1:0] stickyFlags;
    logic [`FRM_STICKY_W-1:0] stickyNew;
    logic [`FRM_GATE_W-1:0] gateLive;
    logic [`FRM_GATE_W-1:0] gateEnable;
    logic [`FRM_CAT_N-1:0] catHit;
    logic gateAssert;
    modport bank (output stickyEvt, output stickyClr, input stickyFlags, input stickyNew,
                  output gateLive, output gateEnable, input catHit, input gateAssert);
    modport latch (input stickyEvt, input stickyClr, output stickyFlags, output stickyNew);
    modport gate (input gateLive, input gateEnable, output catHit, output gateAssert);
endinterface : frm_core_if

// ### verilog/frm_sticky_bank.sv
// Write-one-to-clear fault latches
`timescale 1ns/1ns
`include "frm_cfg.svh"
module frm_sticky_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Core link
    frm_core_if.latch core
);
    logic [`FRM_STICKY_W-1:0] flag_ff;

    genvar i;
    generate
        for (i = 0; i < `FRM_STICKY_W; i++) begin : g_bit
            // An event in the clearing cycle keeps the bit set
            always_ff @(posedge clk) begin
                if (reset) begin
                    flag_ff[i] <= 1'b0;
                end else if (core.stickyEvt[i]) begin
                    flag_ff[i] <= 1'b1;
                end else if (core.stickyClr[i]) begin
                    flag_ff[i] <= 1'b0;
                end
            end
            assign core.stickyNew[i] = core.stickyEvt[i] & ~flag_ff[i];
        end
    endgenerate

    assign core.stickyFlags = flag_ff;
endmodule : frm_sticky_bank

// ### verilog/frm_reset_gate.sv
// Gates live fault status with the reset enables
`timescale 1ns/1ns
`include "frm_cfg.svh"
module frm_reset_gate (
    // Core link
    frm_core_if.gate core
);
    logic [`FRM_GATE_W-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < `FRM_GATE_W; i++) begin : g_src
            assign hit[i] = core.gateLive[i] & core.gateEnable[i];
        end
    endgenerate

    assign core.catHit[0] = |hit[`FRM_GATE_OV_LO-1:`FRM_GATE_UV_LO];
    assign core.catHit[1] = |hit[`FRM_GATE_WARN_LO-1:`FRM_GATE_OV_LO];
    assign core.catHit[2] = |hit[`FRM_GATE_OT_LO-1:`FRM_GATE_WARN_LO];
    assign core.catHit[3] = |hit[`FRM_GATE_MISC_LO-1:`FRM_GATE_OT_LO];
    assign core.catHit[4] = |hit[`FRM_GATE_W-1:`FRM_GATE_MISC_LO];
    assign core.gateAssert = |hit;
endmodule : frm_reset_gate

// ### verilog/frm_fault_reset_mask_bank.sv
// Fault latch tail, reset enable registers, reset pin and interrupt logic
`timescale 1ns/1ns
`include "frm_cfg.svh"

// Behaviour
// - A thermal shutdown event sets sticky bit 6 of the fault latch word, which stays set.
// - Bits 5, 4 and 3 latch input overvoltage of regulators five, three and one.
// - Bits 2, 1 and 0 latch input undervoltage of regulators five, three and one.
// - A reset enable field of 1 lets its live status reach the reset pin, 0 blocks it.
// - The undervoltage enable holds monitors at 13 and 12, regulators at 11 to 0.
// - The undervoltage enable resets with bits 14, 11, 10, 5, 2, 1 and 0 set.
// - The overvoltage enable holds monitors at 13 and 12, regulators at 11 to 0.
// - The overvoltage enable resets with bits 11, 10, 5, 2, 1 and 0 set.
// - The warning enable has the overvoltage layout and resets to all zero.
// - The overtemperature enable has twelve fields, all reset to zero.
// - The misc enable gates six sources at bits 28 to 23, all reset to zero.
module frm_fault_reset_mask_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,

    // Register port, address and write side
    input wire logic [`FRM_ADDR_W-1:0] regAddr,
    input wire logic [`FRM_DATA_W-1:0] regWrData,
    input wire logic regWrEn,

    // Register port, read side
    input wire logic regRdEn,
    output logic [`FRM_DATA_W-1:0] regRdData,

    // Thermal event
    input wire logic thermalShutdown,

    // Regulator input overvoltage events
    input wire logic ldoFiveInputOvervoltage,
    input wire logic ldoThreeInputOvervoltage,
    input wire logic ldoOneInputOvervoltage,

    // Regulator input undervoltage events
    input wire logic ldoFiveInputUndervoltage,
    input wire logic ldoThreeInputUndervoltage,
    input wire logic ldoOneInputUndervoltage,

    // Live undervoltage status
    input wire logic ioSupplyLockoutLive,
    input wire logic [`FRM_UV_W-2:0] uvLive,

    // Live overvoltage status
    input wire logic [`FRM_OV_W-1:0] ovLive,

    // Live warning status
    input wire logic [`FRM_WARN_W-1:0] warnLive,

    // Live overtemperature status
    input wire logic [`FRM_OT_W-1:0] otLive,

    // Live misc status
    input wire logic watchdogInputOneEdge,
    input wire logic watchdogInputZeroEdge,
    input wire logic outputSelectPinDetect,
    input wire logic modePinDetect,
    input wire logic clockSyncFail,
    input wire logic watchdogInputOnePulseFail,

    // Reset pin
    output logic resetOutN,

    // Interrupt
    output logic irq
);
    frm_core_if core ();

    // Register state
    logic [`FRM_UV_W-1:0] undervoltageResetEnable_ff;
    logic [`FRM_OV_W-1:0] overvoltageResetEnable_ff;
    logic [`FRM_WARN_W-1:0] warningResetEnable_ff;
    logic [`FRM_OT_W-1:0] overtemperatureResetEnable_ff;
    logic [`FRM_MISC_W-1:0] miscResetEnable_ff;
    logic [`FRM_IRQ_W-1:0] irqStatus_ff;
    logic [`FRM_IRQ_W-1:0] irqMask_ff;
    logic [`FRM_CAT_N-1:0] catPrev_ff;
    logic [`FRM_DATA_W-1:0] regRdData_ff;
    logic resetOutN_ff;
    logic irq_ff;

    // Next values
    logic [`FRM_DATA_W-1:0] nxt_regRdData;
    logic [`FRM_IRQ_W-1:0] nxt_irqStatus;
    logic nxt_resetOutN;
    logic nxt_irq;

    // Decode and event terms
    frm_pkg::frm_reg_sel_t regSel;
    logic [`FRM_UV_W-1:0] uvAll;
    logic [`FRM_MISC_W-1:0] miscLive;
    logic [`FRM_STICKY_W-1:0] stickyEvents;
    logic [`FRM_CAT_N-1:0] catRise;
    logic [`FRM_IRQ_W-1:0] irqSet;
    logic wrSticky;
    logic wrUv;
    logic wrOv;
    logic wrWarn;
    logic wrOt;
    logic wrMisc;
    logic wrIrqMask;
    logic rdIrqStat;
    logic rdHit;

    // Address decode; the full address is compared so aliases never answer
    always_comb begin
        unique case (regAddr)
            `FRM_OFS_STICKY: regSel = frm_pkg::SEL_STICKY;
            `FRM_OFS_UV_EN: regSel = frm_pkg::SEL_UV_EN;
            `FRM_OFS_OV_EN: regSel = frm_pkg::SEL_OV_EN;
            `FRM_OFS_WARN_EN: regSel = frm_pkg::SEL_WARN_EN;
            `FRM_OFS_OT_EN: regSel = frm_pkg::SEL_OT_EN;
            `FRM_OFS_MISC_EN: regSel = frm_pkg::SEL_MISC_EN;
            `FRM_OFS_IRQ_STAT: regSel = frm_pkg::SEL_IRQ_STAT;
            `FRM_OFS_IRQ_MASK: regSel = frm_pkg::SEL_IRQ_MASK;
            default: regSel = frm_pkg::SEL_NONE;
        endcase
    end

    assign rdHit = regRdEn & (regSel != frm_pkg::SEL_NONE);

    // One strobe per word keeps each register process to a single term
    assign wrSticky = regWrEn & (regSel == frm_pkg::SEL_STICKY);
    assign wrUv = regWrEn & (regSel == frm_pkg::SEL_UV_EN);
    assign wrOv = regWrEn & (regSel == frm_pkg::SEL_OV_EN);
    assign wrWarn = regWrEn & (regSel == frm_pkg::SEL_WARN_EN);
    assign wrOt = regWrEn & (regSel == frm_pkg::SEL_OT_EN);
    assign wrMisc = regWrEn & (regSel == frm_pkg::SEL_MISC_EN);
    assign wrIrqMask = regWrEn & (regSel == frm_pkg::SEL_IRQ_MASK);
    assign rdIrqStat = regRdEn & (regSel == frm_pkg::SEL_IRQ_STAT);

    // Sticky event routing into the latch word
    always_comb begin
        stickyEvents = `FRM_STICKY_RST_VAL;
        stickyEvents[`FRM_BIT_THERMAL] = thermalShutdown;
        stickyEvents[`FRM_BIT_LDO5_OV] = ldoFiveInputOvervoltage;
        stickyEvents[`FRM_BIT_LDO3_OV] = ldoThreeInputOvervoltage;
        stickyEvents[`FRM_BIT_LDO1_OV] = ldoOneInputOvervoltage;
        stickyEvents[`FRM_BIT_LDO5_UV] = ldoFiveInputUndervoltage;
        stickyEvents[`FRM_BIT_LDO3_UV] = ldoThreeInputUndervoltage;
        stickyEvents[`FRM_BIT_LDO1_UV] = ldoOneInputUndervoltage;
    end

    assign core.stickyEvt = stickyEvents;

    // Write one clears only the written ones; a write of zero is harmless
    assign core.stickyClr = wrSticky ?
                            regWrData[`FRM_STICKY_W-1:0] : `FRM_STICKY_RST_VAL;

    frm_sticky_bank u_sticky (
        .clk(clk),
        .reset(reset),
        .core(core)
    );

    // Live status assembly in gate order
    always_comb begin
        uvAll = {1'b0, uvLive};
        uvAll[`FRM_BIT_IO_LOCKOUT] = ioSupplyLockoutLive;
    end

    always_comb begin
        miscLive = `FRM_MISC_RST_VAL;
        miscLive[`FRM_MISC_WD1_EDGE] = watchdogInputOneEdge;
        miscLive[`FRM_MISC_WD0_EDGE] = watchdogInputZeroEdge;
        miscLive[`FRM_MISC_OSEL] = outputSelectPinDetect;
        miscLive[`FRM_MISC_MODE] = modePinDetect;
        miscLive[`FRM_MISC_SYNC] = clockSyncFail;
        miscLive[`FRM_MISC_WD1_PULSE] = watchdogInputOnePulseFail;
    end

    assign core.gateLive = {miscLive, otLive, warnLive, ovLive, uvAll};
    assign core.gateEnable = {miscResetEnable_ff, overtemperatureResetEnable_ff,
                              warningResetEnable_ff, overvoltageResetEnable_ff,
                              undervoltageResetEnable_ff};

    frm_reset_gate u_gate (
        .core(core)
    );

    // Undervoltage reset enable
    always_ff @(posedge clk) begin
        if (reset) begin
            undervoltageResetEnable_ff <= `FRM_UV_RST_VAL;
        end else if (wrUv) begin
            undervoltageResetEnable_ff <= regWrData[`FRM_UV_W-1:0];
        end
    end

    // Overvoltage reset enable
    always_ff @(posedge clk) begin
        if (reset) begin
            overvoltageResetEnable_ff <= `FRM_OV_RST_VAL;
        end else if (wrOv) begin
            overvoltageResetEnable_ff <= regWrData[`FRM_OV_W-1:0];
        end
    end

    // Warning reset enable
    always_ff @(posedge clk) begin
        if (reset) begin
            warningResetEnable_ff <= `FRM_WARN_RST_VAL;
        end else if (wrWarn) begin
            warningResetEnable_ff <= regWrData[`FRM_WARN_W-1:0];
        end
    end

    // Overtemperature reset enable
    always_ff @(posedge clk) begin
        if (reset) begin
            overtemperatureResetEnable_ff <= `FRM_OT_RST_VAL;
        end else if (wrOt) begin
            overtemperatureResetEnable_ff <= regWrData[`FRM_OT_W-1:0];
        end
    end

    // Misc reset enable; only the six covered fields are stored
    always_ff @(posedge clk) begin
        if (reset) begin
            miscResetEnable_ff <= `FRM_MISC_RST_VAL;
        end else if (wrMisc) begin
            miscResetEnable_ff <= regWrData[`FRM_MISC_HI:`FRM_MISC_LO];
        end
    end

    // Reset pin; held low during device reset so loads never see a glitch high
    assign nxt_resetOutN = ~core.gateAssert;

    always_ff @(posedge clk) begin
        if (reset) begin
            resetOutN_ff <= 1'b0;
        end else begin
            resetOutN_ff <= nxt_resetOutN;
        end
    end

    // Category history, so a category raises its status bit once per rise
    always_ff @(posedge clk) begin
        if (reset) begin
            catPrev_ff <= `FRM_CAT_RST_VAL;
        end else begin
            catPrev_ff <= core.catHit;
        end
    end

    assign catRise = core.catHit & ~catPrev_ff;

    // Latch rises fill the low status bits, category rises the bits above them
    always_comb begin
        irqSet = `FRM_IRQ_RST_VAL;
        irqSet[`FRM_STICKY_W-1:0] = core.stickyNew;
        irqSet[`FRM_IRQ_CAT_HI:`FRM_IRQ_CAT_LO] = catRise;
    end

    // Read clears the status, but an event in the same cycle survives
    always_comb begin
        nxt_irqStatus = irqStatus_ff | irqSet;
        if (rdIrqStat) begin
            nxt_irqStatus = irqSet;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus_ff <= `FRM_IRQ_RST_VAL;
        end else begin
            irqStatus_ff <= nxt_irqStatus;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            irqMask_ff <= `FRM_IRQ_RST_VAL;
        end else if (wrIrqMask) begin
            irqMask_ff <= regWrData[`FRM_IRQ_W-1:0];
        end
    end

    // Interrupt level follows the next status so it never lags a read clear
    assign nxt_irq = |(nxt_irqStatus & irqMask_ff);

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // Read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        nxt_regRdData = `FRM_WORD_ZERO;
        if (rdHit) begin
            unique case (regSel)
                frm_pkg::SEL_STICKY: begin
                    nxt_regRdData[`FRM_STICKY_W-1:0] = core.stickyFlags;
                end
                frm_pkg::SEL_UV_EN: begin
                    nxt_regRdData[`FRM_UV_W-1:0] = undervoltageResetEnable_ff;
                end
                frm_pkg::SEL_OV_EN: begin
                    nxt_regRdData[`FRM_OV_W-1:0] = overvoltageResetEnable_ff;
                end
                frm_pkg::SEL_WARN_EN: begin
                    nxt_regRdData[`FRM_WARN_W-1:0] = warningResetEnable_ff;
                end
                frm_pkg::SEL_OT_EN: begin
                    nxt_regRdData[`FRM_OT_W-1:0] = overtemperatureResetEnable_ff;
                end
                frm_pkg::SEL_MISC_EN: begin
                    nxt_regRdData[`FRM_MISC_HI:`FRM_MISC_LO] = miscResetEnable_ff;
                end
                frm_pkg::SEL_IRQ_STAT: begin
                    nxt_regRdData[`FRM_IRQ_W-1:0] = irqStatus_ff;
                end
                frm_pkg::SEL_IRQ_MASK: begin
                    nxt_regRdData[`FRM_IRQ_W-1:0] = irqMask_ff;
                end
                frm_pkg::SEL_NONE: begin
                    nxt_regRdData = `FRM_WORD_ZERO;
                end
            endcase
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdData_ff <= `FRM_WORD_ZERO;
        end else begin
            regRdData_ff <= nxt_regRdData;
        end
    end

    // Reserved bits and unmapped words have no strobe, so writes to them are dropped

    assign regRdData = regRdData_ff;
    assign resetOutN = resetOutN_ff;
    assign irq = irq_ff;
endmodule : frm_fault_reset_mask_bank

// ### verilog/frm_sticky_bank_unused.sv
// Spare source slot of the fault reset bank; it holds no logic

// ### verif/frm_bank_properties.sv
// Port-level properties of the fault reset bank
`timescale 1ns/1ns
`include "frm_cfg.svh"
module frm_bank_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [`FRM_ADDR_W-1:0] regAddr,
    input wire logic [`FRM_DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [`FRM_DATA_W-1:0] regRdData,
    // Events and live status
    input wire logic thermalShutdown,
    input wire logic ioSupplyLockoutLive,
    input wire logic [`FRM_UV_W-2:0] uvLive,
    input wire logic [`FRM_OV_W-1:0] ovLive,
    input wire logic [`FRM_WARN_W-1:0] warnLive,
    input wire logic [`FRM_OT_W-1:0] otLive,
    input wire logic watchdogInputOneEdge,
    input wire logic watchdogInputZeroEdge,
    input wire logic outputSelectPinDetect,
    input wire logic modePinDetect,
    input wire logic clockSyncFail,
    input wire logic watchdogInputOnePulseFail,
    // Pin and interrupt
    input wire logic resetOutN,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic lockEn_ff;
    logic otherLive;
    assign otherLive = |uvLive | |ovLive | |warnLive | |otLive | watchdogInputOneEdge
        | watchdogInputZeroEdge | outputSelectPinDetect | modePinDetect | clockSyncFail
        | watchdogInputOnePulseFail;
    // Mirror of the lockout enable, so pin checks follow software writes
    always_ff @(posedge clk) begin
        if (reset) begin
            lockEn_ff <= 1'b1;
        end else if (regWrEn && regAddr == `FRM_OFS_UV_EN) begin
            lockEn_ff <= regWrData[14];
        end
    end
    property rsvdZero(logic [15:0] a, logic [31:0] m);
        $past(regRdEn) && $past(regAddr) == a |-> (regRdData & m) == '0;
    endproperty
    a_uv_reserved: assert property (rsvdZero(`FRM_OFS_UV_EN, 32'hFFFF_8000))
        else $error("undervoltage enable reserved bits not zero");
    a_ov_reserved: assert property (rsvdZero(`FRM_OFS_OV_EN, 32'hFFFF_C000))
        else $error("overvoltage enable reserved bits not zero");
    a_warn_reserved: assert property (rsvdZero(`FRM_OFS_WARN_EN, 32'hFFFF_C000))
        else $error("warning enable reserved bits not zero");
    a_ot_reserved: assert property (rsvdZero(`FRM_OFS_OT_EN, 32'hFFFF_F000))
        else $error("overtemperature enable reserved bits not zero");
    a_misc_reserved: assert property (rsvdZero(`FRM_OFS_MISC_EN, 32'hE07F_FFFF))
        else $error("misc enable reserved bits not zero");
    a_thermal_sticky: assert property (thermalShutdown ##1
        !(regWrEn && regAddr == `FRM_OFS_STICKY) ##1
        (regRdEn && regAddr == `FRM_OFS_STICKY) |=> regRdData[6])
        else $error("thermal latch bit not set after event");
    a_lockout_pulls: assert property (ioSupplyLockoutLive && lockEn_ff |=> !resetOutN)
        else $error("enabled lockout did not pull the reset pin");
    a_lockout_blocked: assert property (!otherLive && !lockEn_ff |=> resetOutN)
        else $error("blocked lockout reached the reset pin");
    a_pin_release: assert property (!otherLive && !ioSupplyLockoutLive |=> resetOutN)
        else $error("reset pin low with no live source");
    c_pin_pulse: cover property (!resetOutN ##1 resetOutN);
    c_irq_high: cover property (irq);
    c_lock_low: cover property (ioSupplyLockoutLive && lockEn_ff ##1 !resetOutN);
endmodule : frm_bank_properties

bind frm_fault_reset_mask_bank frm_bank_properties frm_bank_properties_inst (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .thermalShutdown(thermalShutdown),
    .ioSupplyLockoutLive(ioSupplyLockoutLive), .uvLive(uvLive), .ovLive(ovLive),
    .warnLive(warnLive), .otLive(otLive), .watchdogInputOneEdge(watchdogInputOneEdge),
    .watchdogInputZeroEdge(watchdogInputZeroEdge), .outputSelectPinDetect(outputSelectPinDetect),
    .modePinDetect(modePinDetect), .clockSyncFail(clockSyncFail),
    .watchdogInputOnePulseFail(watchdogInputOnePulseFail), .resetOutN(resetOutN), .irq(irq));

// ### verif/frm_fault_reset_mask_bank_test.sv
// Self-checking bench of the fault reset bank
`timescale 1ns/1ns
module frm_fault_reset_mask_bank_test;
    logic clk;
    logic reset;
    logic [15:0] regAddr;
    logic [31:0] regWrData;
    logic regWrEn;
    logic regRdEn;
    logic [31:0] regRdData;
    logic [6:0] evt;
    logic ioSupplyLockoutLive;
    logic [13:0] uvLive;
    logic [13:0] ovLive;
    logic [13:0] warnLive;
    logic [11:0] otLive;
    logic [5:0] miscLive;
    logic resetOutN;
    logic irq;
    logic [31:0] rd;
    logic [31:0] d;
    logic [31:0] en [0:4];
    logic [15:0] addrs [0:4] = '{16'h2034, 16'h2038, 16'h203C, 16'h2040, 16'h2044};
    logic [31:0] rstVal [0:4] = '{32'h0000_4C27, 32'h0000_0C27, 32'h0, 32'h0, 32'h0};
    logic [31:0] wMask [0:4] = '{32'h0000_7FFF, 32'h0000_3FFF, 32'h0000_3FFF, 32'h0000_0FFF,
        32'h1F80_0000};
    integer seed = 10;
    integer nMismatch = 0;
    integer samplesChecked = 0;
    integer cycles = 0;
    integer i;
    integer k;
    frm_fault_reset_mask_bank frm_fault_reset_mask_bank_inst (
        .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .thermalShutdown(evt[6]), .ldoFiveInputOvervoltage(evt[5]),
        .ldoThreeInputOvervoltage(evt[4]), .ldoOneInputOvervoltage(evt[3]),
        .ldoFiveInputUndervoltage(evt[2]), .ldoThreeInputUndervoltage(evt[1]),
        .ldoOneInputUndervoltage(evt[0]), .ioSupplyLockoutLive(ioSupplyLockoutLive),
        .uvLive(uvLive), .ovLive(ovLive), .warnLive(warnLive), .otLive(otLive),
        .watchdogInputOneEdge(miscLive[5]), .watchdogInputZeroEdge(miscLive[4]),
        .outputSelectPinDetect(miscLive[3]), .modePinDetect(miscLive[2]),
        .clockSyncFail(miscLive[1]), .watchdogInputOnePulseFail(miscLive[0]),
        .resetOutN(resetOutN), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch = nMismatch + 1;
            finish_test();
        end
    end
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked = samplesChecked + 1;
        if (got !== exp) begin
            nMismatch = nMismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkWord
    task automatic chkPin(input logic got, input logic exp);
        samplesChecked = samplesChecked + 1;
        if (got !== exp) begin
            nMismatch = nMismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkPin
    task automatic wrReg(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : wrReg
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdReg(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 v = regRdData;
    endtask : rdReg
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= '0;
    endtask : pulse
    function automatic logic expPin();
        return ~(|({ioSupplyLockoutLive, uvLive} & en[0][14:0]) | |(ovLive & en[1][13:0])
            | |(warnLive & en[2][13:0]) | |(otLive & en[3][11:0]) | |(miscLive & en[4][28:23]));
    endfunction : expPin
    task finish_test();
        $display("checked %0d, mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        reset = 1'b1;
        {regAddr, regWrData, regWrEn, regRdEn, evt} = '0;
        {ioSupplyLockoutLive, uvLive, ovLive, warnLive, otLive, miscLive} = '0;
        repeat (16) @(posedge clk);
        chkPin(resetOutN, 1'b0);
        reset <= 1'b0;
        for (k = 0; k < 5; k++) begin
            rdReg(addrs[k], rd);
            chkWord(rd, rstVal[k]);
            en[k] = rstVal[k];
        end
        rdReg(16'h2030, rd);
        chkWord(rd, 32'h0);
        wrReg(16'h2048, 32'hFFFF_FFFF);
        rdReg(16'h2048, rd);
        chkWord(rd, 32'h0);
        $display("reset values done");
        // First pass writes all ones, then random enables against sparse live status
        for (i = 0; i < 24; i++) begin
            for (k = 0; k < 5; k++) begin
                d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
                wrReg(addrs[k], d);
                rdReg(addrs[k], rd);
                en[k] = d & wMask[k];
                chkWord(rd, en[k]);
            end
            @(posedge clk);
            ioSupplyLockoutLive <= (i % 3) ? 1'($random(seed)) : 1'b0;
            uvLive <= (i % 3) ? 14'($random(seed) & $random(seed) & $random(seed)) : '0;
            ovLive <= (i % 3) ? 14'($random(seed) & $random(seed) & $random(seed)) : '0;
            warnLive <= (i % 3) ? 14'($random(seed) & $random(seed) & $random(seed)) : '0;
            otLive <= (i % 3) ? 12'($random(seed) & $random(seed) & $random(seed)) : '0;
            miscLive <= (i % 3) ? 6'($random(seed) & $random(seed)) : '0;
            repeat (2) @(posedge clk);
            #1 chkPin(resetOutN, expPin());
        end
        {ioSupplyLockoutLive, uvLive, ovLive, warnLive, otLive, miscLive} <= '0;
        $display("enable and pin done");
        for (k = 0; k < 7; k++) begin
            pulse(7'(1 << k));
            rdReg(16'h2030, rd);
            chkWord(rd, (32'h2 << k) - 1);
        end
        wrReg(16'h2030, 32'h0000_0055);
        rdReg(16'h2030, rd);
        chkWord(rd, 32'h0000_002A);
        wrReg(16'h2030, 32'h0);
        rdReg(16'h2030, rd);
        chkWord(rd, 32'h0000_002A);
        // Event in the same cycle as its clear must win
        @(posedge clk);
        regAddr <= 16'h2030;
        regWrData <= 32'h0000_0040;
        regWrEn <= 1'b1;
        evt <= 7'h40;
        @(posedge clk);
        regWrEn <= 1'b0;
        evt <= '0;
        rdReg(16'h2030, rd);
        chkWord(rd, 32'h0000_006A);
        wrReg(16'h2030, 32'h0000_007F);
        rdReg(16'h2030, rd);
        chkWord(rd, 32'h0);
        $display("latch done");
        rdReg(16'h2100, rd);
        wrReg(16'h2104, 32'h0000_0040);
        pulse(7'h40);
        @(posedge clk);
        #1 chkPin(irq, 1'b1);
        rdReg(16'h2100, rd);
        chkWord(rd & 32'h40, 32'h40);
        chkPin(irq, 1'b0);
        wrReg(16'h2104, 32'h0);
        wrReg(16'h2030, 32'h0000_0040);
        pulse(7'h40);
        repeat (2) @(posedge clk);
        #1 chkPin(irq, 1'b0);
        $display("interrupt done");
        finish_test();
    end
endmodule : frm_fault_reset_mask_bank_test
